/* File: rtl/fast_clk_divider.sv */
/*
 * divider of the fast clock, counting only while run_in is high; gives a one-cycle tick every
 * 2**ratio cycles, ratio 0 to 6.
 * assumes sys_clk_in stands for the fast oscillator clock.
 */
`timescale 1ns/1ps
`default_nettype none

module fast_clk_divider (
    input  wire logic       sys_clk_in,
    input  wire logic       reset_in,
    input  wire logic       run_in,
    input  wire logic [2:0] ratio_in,
    output logic            tick_out
);

    logic [sysclk_pkg::DIV_W-1:0] count_r;
    logic [sysclk_pkg::DIV_W-1:0] mask;

    // counter stops with the oscillator, so no tick leaks while off
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            count_r <= '0;
        end else if (run_in) begin
            count_r <= count_r + 1'b1;
        end
    end

    always_comb begin
        mask     = sysclk_pkg::DIV_W'((7'h01 << ratio_in) - 7'h01);
        tick_out = run_in && ((count_r & mask) == mask);
    end

endmodule : fast_clk_divider

`default_nettype wire

/* File: rtl/pin_sync.sv */
/*
 * two flip-flop synchroniser for one level from outside the clock domain.
 * assumes the level is slow compared with sys_clk_in.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
    input  wire logic sys_clk_in,
    input  wire logic reset_in,
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta_r;

    // meta_r feeds only the second stage
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            meta_r   <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule : pin_sync

`default_nettype wire

/* File: rtl/sysclk_power_ctrl.sv */
/*
 * system clock selection and operating mode control: wishbone register
 * slave, fast/slow cpu clock choice, halt and wake mode sequencing and
 * clock gating of cpu, fast, slow peripheral and watchdog clocks.
 * assumes halt_in and wake_in are one-cycle pulses from logic on
 * sys_clk_in; slow ticks and the oscillator ready level come from pins.
 */
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module sysclk_power_ctrl (
    input  wire logic        sys_clk_in,
    input  wire logic        reset_in,
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [3:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic [31:0]      wb_dat_out,
    output logic             wb_ack_out,
    input  wire logic        halt_in,
    input  wire logic        wake_in,
    input  wire logic        watchdog_en_in,
    input  wire logic        slow_tick_in,
    input  wire logic        fast_osc_ready_in,
    output logic             cpu_run_out,
    output logic             cpu_clk_en_out,
    output logic             sysclk_run_out,
    output logic             fast_clock_run_out,
    output logic             slow_periph_run_out,
    output logic             watchdog_osc_run_out
);

    ////////////////////////////////////////////////////////////////////
    // registers and internal signals

    logic [2:0]               sysclk_select_field;
    logic                     fast_osc_halt_keepalive;
    logic                     slow_osc_halt_keepalive;
    logic                     fast_osc_enable;
    logic                     fast_osc_stable_flag;
    sysclk_pkg::op_mode_e     mode_r;
    sysclk_pkg::op_mode_e     mode_nxt;
    logic                     ack_r;
    logic                     wr_go;
    logic                     rd_go;
    logic                     slow_lvl;
    logic                     slow_lvl_d_r;
    logic                     slow_edge;
    logic                     osc_ready;
    logic                     fast_tick;
    logic                     running;
    logic                     sel_is_slow;
    logic                     cpu_run_nxt;
    logic                     sys_run_nxt;
    logic                     fast_run_nxt;
    logic                     slow_run_nxt;
    logic                     wdt_run_nxt;
    logic [7:0]               rd_byte;

    assign wb_ack_out  = ack_r;
    assign wr_go       = wb_cyc_in && wb_stb_in && wb_we_in && !ack_r
                         && wb_sel_in[0];
    assign rd_go       = wb_cyc_in && wb_stb_in && !wb_we_in && !ack_r;
    assign running     = (mode_r == sysclk_pkg::MODE_FAST) ||
                         (mode_r == sysclk_pkg::MODE_SLOW);
    assign sel_is_slow = (sysclk_select_field == sysclk_pkg::SEL_SLOW);
    assign slow_edge   = slow_lvl && !slow_lvl_d_r;

    ////////////////////////////////////////////////////////////////////
    // pin inputs and fast clock divider

    pin_sync u_slow_sync (
        .sys_clk_in (sys_clk_in),
        .reset_in   (reset_in),
        .async_in   (slow_tick_in),
        .sync_out   (slow_lvl)
    );

    pin_sync u_ready_sync (
        .sys_clk_in (sys_clk_in),
        .reset_in   (reset_in),
        .async_in   (fast_osc_ready_in),
        .sync_out   (osc_ready)
    );

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            slow_lvl_d_r <= 1'b0;
        end else begin
            slow_lvl_d_r <= slow_lvl;
        end
    end

    // divider counts only while the fast oscillator is let run
    fast_clk_divider u_div (
        .sys_clk_in (sys_clk_in),
        .reset_in   (reset_in),
        .run_in     (fast_clock_run_out),
        .ratio_in   (sysclk_select_field),
        .tick_out   (fast_tick)
    );

    ////////////////////////////////////////////////////////////////////
    // wishbone slave: one wait state, ack for one cycle

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wb_cyc_in && wb_stb_in && !ack_r;
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        unique case (wb_adr_in)
            sysclk_pkg::CLOCK_CONTROL_OFS: begin
                rd_byte[sysclk_pkg::SEL_MSB:sysclk_pkg::SEL_LSB] =
                    sysclk_select_field;
                rd_byte[sysclk_pkg::FAST_KA_BIT] = fast_osc_halt_keepalive;
                rd_byte[sysclk_pkg::SLOW_KA_BIT] = slow_osc_halt_keepalive;
            end
            sysclk_pkg::FAST_OSC_CTRL_OFS: begin
                rd_byte[sysclk_pkg::STABLE_BIT] = fast_osc_stable_flag;
                rd_byte[sysclk_pkg::ENABLE_BIT] = fast_osc_enable;
            end
            sysclk_pkg::MODE_STATUS_OFS: begin
                rd_byte[2:0] = mode_r;
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    // unmapped addresses answer with zero
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            wb_dat_out <= 32'h0000_0000;
        end else if (rd_go) begin
            wb_dat_out <= {24'h00_0000, rd_byte};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // clock_control_reg

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            sysclk_select_field     <= sysclk_pkg::SEL_RESET;
            fast_osc_halt_keepalive <= sysclk_pkg::KA_RESET;
            slow_osc_halt_keepalive <= sysclk_pkg::KA_RESET;
        end else if (wr_go &&
                     wb_adr_in == sysclk_pkg::CLOCK_CONTROL_OFS) begin
            sysclk_select_field <=
                wb_dat_in[sysclk_pkg::SEL_MSB:sysclk_pkg::SEL_LSB];
            fast_osc_halt_keepalive <= wb_dat_in[sysclk_pkg::FAST_KA_BIT];
            slow_osc_halt_keepalive <= wb_dat_in[sysclk_pkg::SLOW_KA_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // fast_osc_control_reg

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            fast_osc_enable <= sysclk_pkg::ENABLE_RESET;
        end else if (wr_go &&
                     wb_adr_in == sysclk_pkg::FAST_OSC_CTRL_OFS) begin
            fast_osc_enable <= wb_dat_in[sysclk_pkg::ENABLE_BIT];
        end
    end

    // the ready pin may lag the enable, so a fresh enable forces a clear
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            fast_osc_stable_flag <= sysclk_pkg::STABLE_RESET;
        end else if (wr_go && !fast_osc_enable &&
                     wb_adr_in == sysclk_pkg::FAST_OSC_CTRL_OFS &&
                     wb_dat_in[sysclk_pkg::ENABLE_BIT]) begin
            fast_osc_stable_flag <= 1'b0;
        end else if (!fast_clock_run_out) begin
            fast_osc_stable_flag <= 1'b0;
        end else begin
            fast_osc_stable_flag <= osc_ready;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // mode sequencing

    always_comb begin
        mode_nxt = mode_r;
        unique case (mode_r)
            sysclk_pkg::MODE_FAST,
            sysclk_pkg::MODE_SLOW: begin
                // keep-alives are looked at only here, at halt
                if (halt_in) begin
                    unique case ({fast_osc_halt_keepalive,
                                  slow_osc_halt_keepalive})
                        2'b00: mode_nxt = sysclk_pkg::MODE_SLEEP;
                        2'b01: mode_nxt = sysclk_pkg::MODE_STBY_LOW;
                        2'b11: mode_nxt = sysclk_pkg::MODE_STBY_BOTH;
                        2'b10: mode_nxt = sysclk_pkg::MODE_STBY_HIGH;
                    endcase
                end else if (sel_is_slow) begin
                    mode_nxt = sysclk_pkg::MODE_SLOW;
                end else begin
                    mode_nxt = sysclk_pkg::MODE_FAST;
                end
            end
            sysclk_pkg::MODE_SLEEP,
            sysclk_pkg::MODE_STBY_LOW,
            sysclk_pkg::MODE_STBY_BOTH,
            sysclk_pkg::MODE_STBY_HIGH: begin
                if (wake_in) begin
                    mode_nxt = sel_is_slow ? sysclk_pkg::MODE_SLOW
                                           : sysclk_pkg::MODE_FAST;
                end
            end
            default: begin
                mode_nxt = sysclk_pkg::MODE_FAST;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            mode_r <= sysclk_pkg::MODE_FAST;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // clock gating from the present mode

    always_comb begin
        cpu_run_nxt  = 1'b0;
        sys_run_nxt  = 1'b0;
        fast_run_nxt = 1'b0;
        slow_run_nxt = 1'b0;
        wdt_run_nxt  = 1'b1;
        unique case (mode_r)
            sysclk_pkg::MODE_FAST: begin
                cpu_run_nxt  = 1'b1;
                sys_run_nxt  = 1'b1;
                fast_run_nxt = 1'b1;
                slow_run_nxt = 1'b1;
            end
            sysclk_pkg::MODE_SLOW: begin
                cpu_run_nxt  = 1'b1;
                sys_run_nxt  = 1'b1;
                fast_run_nxt = fast_osc_enable;
                slow_run_nxt = 1'b1;
            end
            sysclk_pkg::MODE_SLEEP: begin
                wdt_run_nxt  = watchdog_en_in;
            end
            sysclk_pkg::MODE_STBY_LOW: begin
                sys_run_nxt  = sel_is_slow;
                slow_run_nxt = 1'b1;
            end
            sysclk_pkg::MODE_STBY_BOTH: begin
                sys_run_nxt  = 1'b1;
                fast_run_nxt = 1'b1;
                slow_run_nxt = 1'b1;
            end
            sysclk_pkg::MODE_STBY_HIGH: begin
                sys_run_nxt  = !sel_is_slow;
                fast_run_nxt = 1'b1;
            end
            default: begin
                wdt_run_nxt  = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            cpu_run_out          <= 1'b1;
            sysclk_run_out       <= 1'b1;
            fast_clock_run_out   <= 1'b1;
            slow_periph_run_out  <= 1'b1;
            watchdog_osc_run_out <= 1'b1;
        end else begin
            cpu_run_out          <= cpu_run_nxt;
            sysclk_run_out       <= sys_run_nxt;
            fast_clock_run_out   <= fast_run_nxt;
            slow_periph_run_out  <= slow_run_nxt;
            watchdog_osc_run_out <= wdt_run_nxt;
        end
    end

    // cpu advance strobe: slow edge for 111, divided fast tick otherwise
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            cpu_clk_en_out <= 1'b0;
        end else begin
            cpu_clk_en_out <= cpu_run_out && (sel_is_slow ?
                              slow_edge : fast_tick);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    sequence s_halt_running;
        running && halt_in;
    endsequence

    sequence s_osc_turn_on;
        wr_go && !fast_osc_enable &&
        wb_adr_in == sysclk_pkg::FAST_OSC_CTRL_OFS &&
        wb_dat_in[sysclk_pkg::ENABLE_BIT];
    endsequence

    property p_halt_sleep;
        @(posedge sys_clk_in) disable iff (reset_in)
        s_halt_running ##0 (!fast_osc_halt_keepalive &&
        !slow_osc_halt_keepalive) |=> mode_r == sysclk_pkg::MODE_SLEEP
        ##1 (!cpu_run_out && !fast_clock_run_out);
    endproperty
    a_halt_sleep: assert property (p_halt_sleep)
        else $error("halt with keep-alives 00 did not give sleep");

    property p_sleep_gates;
        @(posedge sys_clk_in) disable iff (reset_in)
        mode_r == sysclk_pkg::MODE_SLEEP |=> !cpu_run_out &&
        !sysclk_run_out && !fast_clock_run_out && !slow_periph_run_out;
    endproperty
    a_sleep_gates: assert property (p_sleep_gates)
        else $error("a clock runs in sleep");

    property p_wdt_sleep;
        @(posedge sys_clk_in) disable iff (reset_in)
        mode_r == sysclk_pkg::MODE_SLEEP |=>
        watchdog_osc_run_out == $past(watchdog_en_in);
    endproperty
    a_wdt_sleep: assert property (p_wdt_sleep)
        else $error("watchdog clock does not follow its enable in sleep");

    property p_stby_low;
        @(posedge sys_clk_in) disable iff (reset_in)
        mode_r == sysclk_pkg::MODE_STBY_LOW |=> !fast_clock_run_out &&
        slow_periph_run_out && !cpu_run_out &&
        sysclk_run_out == $past(sel_is_slow);
    endproperty
    a_stby_low: assert property (p_stby_low)
        else $error("low-clock standby gating wrong");

    property p_stby_both;
        @(posedge sys_clk_in) disable iff (reset_in)
        mode_r == sysclk_pkg::MODE_STBY_BOTH |=> fast_clock_run_out &&
        slow_periph_run_out && sysclk_run_out && !cpu_run_out;
    endproperty
    a_stby_both: assert property (p_stby_both)
        else $error("both-clock standby gating wrong");

    property p_stby_high;
        @(posedge sys_clk_in) disable iff (reset_in)
        mode_r == sysclk_pkg::MODE_STBY_HIGH |=> fast_clock_run_out &&
        !slow_periph_run_out && !cpu_run_out &&
        sysclk_run_out == !$past(sel_is_slow);
    endproperty
    a_stby_high: assert property (p_stby_high)
        else $error("high-clock standby gating wrong");

    property p_slow_fast_en;
        @(posedge sys_clk_in) disable iff (reset_in)
        mode_r == sysclk_pkg::MODE_SLOW |=>
        fast_clock_run_out == $past(fast_osc_enable) && cpu_run_out;
    endproperty
    a_slow_fast_en: assert property (p_slow_fast_en)
        else $error("fast clock ignores its enable in slow mode");

    property p_fast_all;
        @(posedge sys_clk_in) disable iff (reset_in)
        mode_r == sysclk_pkg::MODE_FAST |=> cpu_run_out &&
        fast_clock_run_out && slow_periph_run_out && watchdog_osc_run_out;
    endproperty
    a_fast_all: assert property (p_fast_all)
        else $error("a clock is off in fast mode");

    property p_stable_clear;
        @(posedge sys_clk_in) disable iff (reset_in)
        s_osc_turn_on |=> !fast_osc_stable_flag;
    endproperty
    a_stable_clear: assert property (p_stable_clear)
        else $error("stable flag not cleared on oscillator enable");

    property p_wake;
        @(posedge sys_clk_in) disable iff (reset_in)
        !running && wake_in |=>
        mode_r == ($past(sel_is_slow) ? sysclk_pkg::MODE_SLOW
                                      : sysclk_pkg::MODE_FAST);
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake did not restore the run mode");

endmodule : sysclk_power_ctrl

`default_nettype wire

/* File: shared/sysclk_pkg.sv */
/*
 * constants for the system clock select and power mode block: register
 * offsets, field positions, reset values, mode codes.
 * assumes a byte-addressed wishbone bus with 32-bit data words.
 */
package sysclk_pkg;

    localparam int          ADR_W = 4;
    localparam int          DAT_W = 32;

    // register byte offsets
    localparam logic [3:0]  CLOCK_CONTROL_OFS = 4'h0;
    localparam logic [3:0]  FAST_OSC_CTRL_OFS = 4'h4;
    localparam logic [3:0]  MODE_STATUS_OFS   = 4'h8;

    // clock_control_reg fields
    localparam int          SEL_LSB    = 5;
    localparam int          SEL_MSB    = 7;
    localparam int          FAST_KA_BIT = 1;
    localparam int          SLOW_KA_BIT = 0;
    localparam logic [2:0]  SEL_RESET  = 3'h0;
    localparam logic [2:0]  SEL_SLOW   = 3'h7;
    localparam logic        KA_RESET   = 1'b0;

    // fast_osc_control_reg fields
    localparam int          STABLE_BIT = 1;
    localparam int          ENABLE_BIT = 0;
    localparam logic        ENABLE_RESET = 1'b1;
    localparam logic        STABLE_RESET = 1'b0;

    // deepest divide ratio is 2**6 = 64
    localparam int          DIV_W = 6;

    typedef enum logic [2:0] {
        MODE_FAST       = 3'b000,
        MODE_SLOW       = 3'b001,
        MODE_SLEEP      = 3'b010,
        MODE_STBY_LOW   = 3'b011,
        MODE_STBY_BOTH  = 3'b100,
        MODE_STBY_HIGH  = 3'b101
    } op_mode_e;

endpackage : sysclk_pkg

/* File: testbench/osc_partner.sv */
/*
 * oscillator side of the clock block: a free-running slow oscillator
 * tick and a fast oscillator ready level that settles after a delay.
 * assumes the fast oscillator runs whenever the block says so.
 */
`timescale 1ns/1ps
`default_nettype none

module osc_partner (
    input  wire logic sys_clk_in,
    input  wire logic reset_in,
    input  wire logic fast_run_in,
    output logic      slow_tick_out,
    output logic      ready_out
);
    logic [3:0] div_r;
    logic [2:0] settle_r;

    // slow oscillator never stops; only the block's gating does
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) div_r <= 4'h0;
        else div_r <= div_r + 4'h1;
    end

    // a restarted oscillator needs seven cycles before it is stable
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) settle_r <= 3'h7;
        else if (!fast_run_in) settle_r <= 3'h0;
        else if (settle_r != 3'h7) settle_r <= settle_r + 3'h1;
    end

    assign slow_tick_out = div_r[3];
    assign ready_out     = (settle_r == 3'h7);
endmodule : osc_partner
`default_nettype wire

/* File: testbench/tb_top.sv */
/*
 * bench for sysclk_power_ctrl: registers, halt and wake modes, cpu
 * strobe rates. assumes osc_partner drives the oscillator pins.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic        sys_clk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0]  adr = 4'h0, sel = 4'h0;
    logic [31:0] dat = 32'h0, rdat, q, n;
    logic        ack, halt = 1'b0, wake = 1'b0, wd_en = 1'b0;
    logic        tick, ready, cpu_run, clk_en, sys_run, f_run, s_run;
    logic        w_run;
    logic [1:0]  ka;
    logic [2:0]  s;
    int          miscompares = 0, tests_run = 0;
    sysclk_pkg::op_mode_e mtab [4] = '{sysclk_pkg::MODE_SLEEP,
        sysclk_pkg::MODE_STBY_LOW, sysclk_pkg::MODE_STBY_HIGH,
        sysclk_pkg::MODE_STBY_BOTH};

    always #10 sys_clk_in = ~sys_clk_in;

    sysclk_power_ctrl dut_u (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .halt_in(halt), .wake_in(wake),
        .watchdog_en_in(wd_en), .slow_tick_in(tick),
        .fast_osc_ready_in(ready), .cpu_run_out(cpu_run),
        .cpu_clk_en_out(clk_en), .sysclk_run_out(sys_run),
        .fast_clock_run_out(f_run), .slow_periph_run_out(s_run),
        .watchdog_osc_run_out(w_run));

    osc_partner osc_u (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
        .fast_run_in(f_run), .slow_tick_out(tick), .ready_out(ready));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // one classic cycle; held until ack, then a full idle cycle
    // a slave that never answers is caught by the bench watchdog
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'h1;
        do begin
            @(posedge sys_clk_in);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge sys_clk_in);
    endtask : wb

    task automatic strobe(input logic h);
        if (h) halt <= 1'b1;
        else wake <= 1'b1;
        @(posedge sys_clk_in);
        halt <= 1'b0;
        wake <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
    endtask : strobe

    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        miscompares++;
        results();
    end

    initial begin
        repeat (4) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        wb(1'b0, 4'h0, 32'h0);
        chk(q, 32'h0);
        wb(1'b0, 4'h4, 32'h0);
        chk(q, 32'h3);
        wb(1'b0, 4'h8, 32'h0);
        chk(q, sysclk_pkg::MODE_FAST);
        wb(1'b0, 4'hC, 32'h0);
        chk(q, 32'h0);
        wb(1'b1, 4'h0, 32'hFF);
        wb(1'b0, 4'h0, 32'h0);
        chk(q, 32'hE3);
        wb(1'b0, 4'h8, 32'h0);
        chk(q, sysclk_pkg::MODE_SLOW);
        chk({cpu_run, sys_run}, 2'b11);
        wb(1'b1, 4'h4, 32'h0);
        repeat (3) @(posedge sys_clk_in);
        chk(f_run, 1'b0);
        wb(1'b0, 4'h4, 32'h0);
        chk(q, 32'h0);
        wb(1'b1, 4'h4, 32'h1);
        wb(1'b0, 4'h4, 32'h0);
        chk(q, 32'h1);
        repeat (16) @(posedge sys_clk_in);
        wb(1'b0, 4'h4, 32'h0);
        chk(q, 32'h3);
        chk(f_run, 1'b1);
        // every keep-alive pair against both select kinds
        for (int i = 0; i < 8; i++) begin
            ka = i[1:0];
            s = i[2] ? 3'h7 : 3'h0;
            wd_en <= i[2];
            wb(1'b1, 4'h0, {24'h0, s, 3'h0, ka});
            strobe(1'b1);
            chk(cpu_run, 1'b0);
            chk(sys_run, ka == 2'h3 || (ka == 2'h1 && s == 3'h7) ||
                (ka == 2'h2 && s != 3'h7));
            chk({f_run, s_run}, ka);
            chk(w_run, ka != 2'h0 || i[2]);
            wb(1'b0, 4'h8, 32'h0);
            chk(q, mtab[ka]);
            strobe(1'b0);
            chk({cpu_run, f_run}, 2'b11);
            wb(1'b0, 4'h8, 32'h0);
            chk(q, {31'h0, s == 3'h7});
        end
        // cpu strobe rate for every select code over 128 cycles
        for (int k = 0; k < 8; k++) begin
            wb(1'b1, 4'h0, {24'h0, k[2:0], 5'h0});
            repeat (8) @(posedge sys_clk_in);
            n = 32'h0;
            repeat (128) begin
                @(posedge sys_clk_in);
                n = n + {31'h0, clk_en};
            end
            chk(n, k == 7 ? 32'h8 : 32'h80 >> k);
        end
        results();
    end
endmodule : tb_top
`default_nettype wire
